/* dv/ahb_host.sv */
`timescale 1ns/100ps
module ahb_host (
    // Clock and bus return
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Bus request
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
    end

    // Single word transfer; called just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule

/* dv/motion_cmd_chk.sv */
`timescale 1ns/100ps
module motion_cmd_chk (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Engine
    input wire logic        sample_tick,
    input wire logic [1:0]  prog_running,
    input wire logic [1:0]  output_pending
);
    logic ctrl_wr;
    wire  acc = hsel && htrans[1] && hready;
    wire  clr0 = ctrl_wr && hwdata[16];
    wire  clr1 = ctrl_wr && hwdata[17];

    // Marks the data phase of a control word write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            ctrl_wr <= 1'b0;
        else if (hready)
            ctrl_wr <= acc && hwrite && haddr == 32'h0000_0000;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    chk_pub_cause_one: assert property ($rose(output_pending[0]) |-> $past(prog_running[0]))
        else $error("latch one set while idle");
    chk_pub_cause_two: assert property ($rose(output_pending[1]) |-> $past(prog_running[1]))
        else $error("latch two set while idle");
    chk_latch_clear_one: assert property (clr0 && !prog_running[0] |=> !output_pending[0])
        else $error("latch one not cleared");
    chk_latch_clear_two: assert property (clr1 && !prog_running[1] |=> !output_pending[1])
        else $error("latch two not cleared");
    chk_latch_keep: assert property (output_pending[0] && !clr0 |=> output_pending[0])
        else $error("latch one dropped without host");
    chk_status_run: assert property (acc && !hwrite && haddr == 32'h0000_0004
        |=> hrdata[17:16] == $past(prog_running))
        else $error("status running bits wrong");

    cover property ($rose(output_pending[0]));
    cover property ($fell(prog_running[1]));
    cover property (clr0 && output_pending[0]);
    cover property (sample_tick ##1 prog_running != 2'b00);
endmodule

bind motion_program_command_exec motion_cmd_chk chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_tick(sample_tick),
    .prog_running(prog_running), .output_pending(output_pending));

/* dv/motion_program_command_exec_tb.sv */
`timescale 1ns/100ps
module motion_program_command_exec_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        sample_tick = 1'b0;
    logic        jump_take = 1'b0;
    logic        jump_which = 1'b0;
    wire         hsel, hwrite, hreadyout, hresp;
    wire  [1:0]  htrans, prog_running, output_pending;
    wire  [2:0]  hsize;
    wire  [31:0] haddr, hwdata, hrdata;
    int          err_count = 0;
    int          n_checks = 0;
    logic [31:0] q;

    initial forever #20 hclk = ~hclk;

    ahb_host host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    motion_program_command_exec dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sample_tick(sample_tick), .cond_prog(1'b0), .cond_next(1'b0), .cond_reset(1'b0),
        .jump_take(jump_take), .jump_which(jump_which), .prog_running(prog_running),
        .output_pending(output_pending));

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s exp %h got %h", nm, e, g);
            err_count++;
        end
    endtask

    task rdchk(input string nm, input logic [31:0] a, m, e);
        host_u.xfer(1'b0, a, '0, q);
        chk(nm, e, q & m);
    endtask

    task wr(input logic [31:0] a, d);
        host_u.xfer(1'b1, a, d, q);
    endtask

    task rst;
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    // Loads n program bytes (first byte leftmost), enables, ticks, lets it run
    task run(input int p, input logic [127:0] b, input int n);
        for (int i = 0; i < n; i++)
            wr(32'h0000_0040 + p * 64 + i * 4, {24'h0, b[127 - 8 * i -: 8]});
        wr(32'h0000_0000, 32'h0000_0001 << p);
        sample_tick <= 1'b1;
        @(posedge hclk);
        sample_tick <= 1'b0;
        repeat (2) @(posedge hclk);
        for (int k = 0; k < 40 && prog_running !== 2'h0; k++)
            @(posedge hclk);
    endtask

    // Branch condition pulse for program one, then lets the engine step
    task jump(input logic w);
        jump_which <= w;
        jump_take  <= 1'b1;
        @(posedge hclk);
        jump_take  <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    initial begin
        repeat (5000) @(posedge hclk);
        err_count++;
        test_done;
    end

    initial begin
        rst;
        rdchk("ctrl_rst", 32'h0000_0000, '1, '0);
        rdchk("status_rst", 32'h0000_0004, '1, '0);
        rdchk("unmapped", 32'h0000_0020, '1, '0);
        $display("test reset done");
        run(0, 128'h775a_8833_413c_1324_550b_07bb_0000_0000, 13);
        rdchk("cfg_thr1", 32'h0000_0008, '1, 32'h005a_0020);
        rdchk("timer3", 32'h0000_000c, '1, 32'h003c_0000);
        rdchk("long_cnt", 32'h0000_0010, 32'hff00_0000, 32'h0600_0000);
        rdchk("ctrl_pub", 32'h0000_0000, 32'h0001_0133, 32'h0001_0010);
        rdchk("restart1", 32'h0000_0004, 32'h0000_00f0, '0);
        chk("pend_pub", 32'h0000_0001, {30'h0, output_pending});
        wr(32'h0000_0000, 32'h0001_0010);
        @(posedge hclk);
        chk("pend_clr", '0, {30'h0, output_pending});
        $display("test program one done");
        rst;
        run(1, 128'h1323_3243_0000_0000_0000_0000_0000_0000, 5);
        rdchk("cfg_two", 32'h0000_0008, 32'h0000_ff00, 32'h0000_3a00);
        rdchk("en_two", 32'h0000_0000, 32'h0000_0003, '0);
        $display("test program two done");
        rst;
        run(0, 128'h2300_0000_0000_0000_0000_0000_0000_0000, 1);
        rdchk("illegal", 32'h0000_0000, 32'h0000_0003, '0);
        rdchk("illegal_cfg", 32'h0000_0008, 32'h0000_ff00, '0);
        chk("illegal_run", '0, {30'h0, prog_running});
        $display("test illegal done");
        rst;
        run(0, 128'h9900_0000_0000_0000_0000_0000_0000_0000, 2);
        chk("hold_pend", 32'h0000_0001, {30'h0, output_pending});
        rdchk("hold_en", 32'h0000_0000, 32'h0001_0003, 32'h0001_0001);
        wr(32'h0000_0000, 32'h0001_0001);
        repeat (6) @(posedge hclk);
        rdchk("hold_done", 32'h0000_0000, 32'h0001_0003, '0);
        $display("test hold done");
        rst;
        run(0, 128'h6601_550e_81cc_3322_5aba_0011_0000_0000, 12);
        rdchk("arm", 32'h0000_0004, 32'h00c0_00ff, 32'h0040_0077);
        rdchk("br_regs", 32'h0000_001c, 32'h0000_ffff, 32'h0000_ba5a);
        jump(1'b1);
        rdchk("resume", 32'h0000_0000, 32'h0001_0003, 32'h0001_0001);
        rdchk("rearm", 32'h0000_0004, 32'h00c0_000f, 32'h0040_0007);
        rdchk("outs", 32'h0000_0018, 32'h0000_00ff, 32'h0000_0042);
        rdchk("trig", 32'h0000_0014, 32'h00ff_0000, 32'h0042_0000);
        wr(32'h0000_0000, 32'h0001_0001);
        jump(1'b0);
        rdchk("halt_emit", 32'h0000_0000, 32'h0001_0003, 32'h0001_0000);
        $display("test branch done");
        test_done;
    end
endmodule

/* hw/cmd_decode.v */
`timescale 1ns/100ps
`include "motion_cmd_defs.vh"

module cmd_decode (
    // Program byte
    input  wire [7:0] op,
    input  wire       second_prog,
    // Classification
    output reg        is_cmd,
    output reg  [1:0] nparam,
    output reg        illegal
);

    always @* begin
        is_cmd  = 1'b1;
        nparam  = 2'd0;
        illegal = 1'b0;
        case (op)
            `OP_HALT, `OP_RESUME, `OP_MARK_RP, `OP_CLEAR_RP,
            `OP_PUB, `OP_PUB_HOLD, `OP_LCNT_DOWN, `OP_SIGN_FLIP,
            `OP_FREE_TEMP, `OP_RENDEZVOUS, `OP_UNSIGNED, `OP_SIGNED,
            `OP_MAIN_MASK, `OP_ALT_MASK, `OP_KEEP_TEMP,
            `OP_AUTO_FREE: begin
                nparam = 2'd0;
            end
            `OP_BRANCH, `OP_WRITE_PARAM_DIRECT: begin
                nparam = 2'd2;
            end
            `OP_CFG1, `OP_THR1, `OP_THR2, `OP_THR3,
            `OP_TIM3, `OP_TIM4: begin
                nparam = 2'd1;
            end
            `OP_RAW, `OP_DELTA, `OP_PLAIN_DIFF, `OP_SHIFT_DIFF: begin
                illegal = ~second_prog;
            end
            default: begin
                is_cmd = 1'b0;
            end
        endcase
    end

endmodule

/* hw/motion_cmd_defs.vh */
`ifndef MOTION_CMD_DEFS_VH
`define MOTION_CMD_DEFS_VH

// Register byte addresses
`define ADDR_CTRL      8'h00
`define ADDR_STATUS    8'h04
`define ADDR_PARAM_LO  8'h08
`define ADDR_PARAM_HI  8'h14
`define ADDR_OUTS      8'h18
`define ADDR_BRANCH    8'h1c
`define ADDR_PROG_LO   8'h40
`define ADDR_PROG_HI   8'hbc

// Control word fields
`define CTRL_EN_LSB    0
`define CTRL_MSEL_LSB  4
`define CTRL_CNT_BIT   8
`define CTRL_LATCH_LSB 16

// Parameter memory byte indexes (per-program pairs: base + program; THR3 and LCNT are single shared bytes)
`define PM_CFG         4'h0
`define PM_THR1        4'h2
`define PM_THR2        4'h4
`define PM_TIM3        4'h6
`define PM_TIM4        4'h8
`define PM_THR3        4'ha
`define PM_LCNT        4'hb
`define PM_MASK        4'hc
`define PM_TRIG        4'he
`define PM_SIZE        16

// Program config bit positions
`define CFG_SIGNED     5
`define CFG_DELTA      4
`define CFG_DSHIFT     3
`define CFG_AUTOFREE   1
`define CFG_EMIT       0

// Reset values
`define RST_BYTE       8'h00
`define RST_WORD       32'h0000_0000
`define RST_PTR        4'h0

// Command codes
`define OP_HALT        8'h00
`define OP_RESUME      8'h11
`define OP_BRANCH      8'h22
`define OP_MARK_RP     8'h33
`define OP_CLEAR_RP    8'h44
`define OP_WRITE_PARAM_DIRECT        8'h55
`define OP_CFG1        8'h66
`define OP_THR1        8'h77
`define OP_PUB         8'h88
`define OP_PUB_HOLD    8'h99
`define OP_THR2        8'haa
`define OP_LCNT_DOWN   8'hbb
`define OP_SIGN_FLIP   8'hcc
`define OP_FREE_TEMP   8'hdd
`define OP_THR3        8'hee
`define OP_RENDEZVOUS  8'hff
`define OP_UNSIGNED    8'h12
`define OP_SIGNED      8'h13
`define OP_MAIN_MASK   8'h14
`define OP_RAW         8'h21
`define OP_DELTA       8'h23
`define OP_ALT_MASK    8'h24
`define OP_PLAIN_DIFF  8'h31
`define OP_SHIFT_DIFF  8'h32
`define OP_KEEP_TEMP   8'h34
`define OP_TIM3        8'h41
`define OP_TIM4        8'h42
`define OP_AUTO_FREE   8'h43

`endif

/* hw/motion_program_command_exec.v */
`timescale 1ns/100ps
`include "motion_cmd_defs.vh"

// Operation
// - Halt code stops the program and points restart pointer at address zero.
// - Resume code jumps execution to the restart pointer at once.
// - Branch code takes condition byte and target byte, then waits per sample.
// - Branch keeps its pointer and arms; jump_take then loads a target nibble.
// - Mark code loads restart pointer with the next state address.
// - Clear code sets restart pointer to address zero.
// - Direct write puts second byte at the absolute parameter address.
// - Config load replaces first settings register with its byte.
// - Threshold codes overwrite threshold one, two, or shared three.
// - Timer codes overwrite the running program's timer three or four.
// - Publish copies outputs to host registers and continues.
// - Publish-and-hold publishes, then stalls until host clears the latch.
// - Counter code decrements long counter and flags it at zero.
// - Sign flip swaps plus and minus bits in mask and trigger.
// - Free code returns temporary output mask to default.
// - Rendezvous waits until the other program also reaches rendezvous or is not enabled.
// - Filter codes clear or set signed_threshold_sel of running program.
// - Mask codes clear or set mask_set_select of running program.
// - Data codes clear or set delta_data_sel in program two.
// - Diff codes clear or set diff_shift_sel in program two.
// - Temp mask codes clear or set auto_axis_mask_free.
// - Program-two-only codes in program one halt it and clear its enable.
// - With stop_resume_exec_emits_output set, halt and resume also publish.
// - Program two pointers are 4-bit, restart pointer in upper nibble.
module motion_program_command_exec (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Condition evaluator
    input  wire        sample_tick,
    input  wire        cond_prog,
    input  wire        cond_next,
    input  wire        cond_reset,
    input  wire        jump_take,
    input  wire        jump_which,
    // Engine state
    output reg  [1:0]  prog_running,
    output reg  [1:0]  output_pending
);

    reg  [7:0]  prog_mem [0:31];
    reg  [7:0]  pmem [0:15];
    reg  [3:0]  pp [0:1];
    reg  [3:0]  rp [0:1];
    reg  [7:0]  outreg [0:1];
    reg  [7:0]  temp_mask [0:1];
    reg  [7:0]  br_cond [0:1];
    reg  [7:0]  br_targ [0:1];
    reg  [1:0]  en;
    reg  [1:0]  msel;
    reg  [1:0]  hold;
    reg  [1:0]  sync;
    reg  [1:0]  armed;
    reg         counter_hit;
    reg         wr_pend;
    reg  [7:0]  wr_addr;
    reg  [31:0] next_rdata;
    integer     i;

    wire        is_cmd;
    wire [1:0]  nparam;
    wire        illegal;

    function [3:0] pidx;
        input [3:0] base;
        input       p;
        begin
            pidx = base + {3'b000, p};
        end
    endfunction

    function is_prog;
        input [7:0] a;
        begin
            is_prog = (a >= `ADDR_PROG_LO) && (a <= `ADDR_PROG_HI);
        end
    endfunction

    function [4:0] prog_idx;
        input [7:0] a;
        reg   [7:0] off;
        begin
            off      = a - `ADDR_PROG_LO;
            prog_idx = off[6:2];
        end
    endfunction

    function is_param;
        input [7:0] a;
        begin
            is_param = (a >= `ADDR_PARAM_LO) && (a <= `ADDR_PARAM_HI);
        end
    endfunction

    function [1:0] param_word;
        input [7:0] a;
        begin
            param_word = a[3:2] - 2'd2;
        end
    endfunction

    function [7:0] swap_sign;
        input [7:0] v;
        begin
            swap_sign = {v[6], v[7], v[4], v[5], v[2], v[3], v[0], v[1]};
        end
    endfunction

    // Program selection: program one has priority when both may step
    wire       act0 = prog_running[0] & en[0] & ~hold[0] & ~sync[0] & ~armed[0];
    wire       act1 = prog_running[1] & en[1] & ~hold[1] & ~sync[1] & ~armed[1];
    wire       svc  = ~act0;
    wire       act  = act0 | act1;
    wire [3:0] cpp  = pp[svc];
    wire [3:0] pp1  = cpp + 4'd1;
    wire [3:0] pp2  = cpp + 4'd2;
    wire [7:0] op   = prog_mem[{svc, cpp}];
    wire [7:0] par1 = prog_mem[{svc, pp1}];
    wire [7:0] par2 = prog_mem[{svc, pp2}];
    wire [3:0] npp  = pp1 + {2'b00, nparam};
    wire       emit = pmem[pidx(`PM_CFG, svc)][`CFG_EMIT];
    wire [7:0] lcnt = pmem[`PM_LCNT];
    wire       addr_ok = hsel && htrans[1] && hready && (haddr[31:8] == 24'h00_0000)
                         && (haddr[1:0] == 2'b00);
    wire       sync_done = (sync[0] | ~en[0]) & (sync[1] | ~en[1]) & (|sync);

    cmd_decode u_dec (
        .op          (op),
        .second_prog (svc),
        .is_cmd      (is_cmd),
        .nparam      (nparam),
        .illegal     (illegal)
    );

    // Read data for the address phase being accepted
    always @* begin
        next_rdata = `RST_WORD;
        if (haddr[7:0] == `ADDR_CTRL) begin
            next_rdata = {14'h0000, output_pending, 7'h00, counter_hit,
                          2'b00, msel, 2'b00, en};
        end else if (haddr[7:0] == `ADDR_STATUS) begin
            next_rdata = {8'h00, armed, sync, hold, prog_running,
                          rp[1], pp[1], rp[0], pp[0]};
        end else if (is_param(haddr[7:0])) begin
            next_rdata = {pmem[{param_word(haddr[7:0]), 2'b11}],
                          pmem[{param_word(haddr[7:0]), 2'b10}],
                          pmem[{param_word(haddr[7:0]), 2'b01}],
                          pmem[{param_word(haddr[7:0]), 2'b00}]};
        end else if (haddr[7:0] == `ADDR_OUTS) begin
            next_rdata = {temp_mask[1], temp_mask[0], outreg[1], outreg[0]};
        end else if (haddr[7:0] == `ADDR_BRANCH) begin
            next_rdata = {br_targ[1], br_cond[1], br_targ[0], br_cond[0]};
        end else if (is_prog(haddr[7:0])) begin
            next_rdata = {24'h00_0000, prog_mem[prog_idx(haddr[7:0])]};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < 32; i = i + 1) begin
                prog_mem[i] <= `RST_BYTE;
            end
            for (i = 0; i < `PM_SIZE; i = i + 1) begin
                pmem[i] <= `RST_BYTE;
            end
            for (i = 0; i < 2; i = i + 1) begin
                pp[i]        <= `RST_PTR;
                rp[i]        <= `RST_PTR;
                outreg[i]    <= `RST_BYTE;
                temp_mask[i] <= `RST_BYTE;
                br_cond[i]   <= `RST_BYTE;
                br_targ[i]   <= `RST_BYTE;
            end
            en             <= 2'b00;
            msel           <= 2'b00;
            hold           <= 2'b00;
            sync           <= 2'b00;
            armed          <= 2'b00;
            counter_hit    <= 1'b0;
            prog_running   <= 2'b00;
            output_pending <= 2'b00;
            wr_pend        <= 1'b0;
            wr_addr        <= 8'h00;
            hrdata         <= `RST_WORD;
            hreadyout      <= 1'b1;
            hresp          <= 1'b0;
        end else begin
            // Bus address phase
            wr_pend <= addr_ok & hwrite;
            wr_addr <= haddr[7:0];
            if (addr_ok & ~hwrite) begin
                hrdata <= next_rdata;
            end

            // Bus data phase writes
            if (wr_pend) begin
                if (wr_addr == `ADDR_CTRL) begin
                    en   <= hwdata[`CTRL_EN_LSB +: 2];
                    msel <= hwdata[`CTRL_MSEL_LSB +: 2];
                    if (hwdata[`CTRL_CNT_BIT]) begin
                        counter_hit <= 1'b0;
                    end
                    output_pending <= output_pending
                                      & ~hwdata[`CTRL_LATCH_LSB +: 2];
                end else if (is_param(wr_addr)) begin
                    pmem[{param_word(wr_addr), 2'b00}] <= hwdata[7:0];
                    pmem[{param_word(wr_addr), 2'b01}] <= hwdata[15:8];
                    pmem[{param_word(wr_addr), 2'b10}] <= hwdata[23:16];
                    pmem[{param_word(wr_addr), 2'b11}] <= hwdata[31:24];
                end else if (is_prog(wr_addr)) begin
                    prog_mem[prog_idx(wr_addr)] <= hwdata[7:0];
                end
            end

            // New sample wakes every enabled program
            if (sample_tick) begin
                prog_running <= prog_running | en;
            end

            // Condition evaluator results
            if (cond_next) begin
                pp[cond_prog]           <= pp[cond_prog] + 4'd1;
                prog_running[cond_prog] <= en[cond_prog];
                if (pmem[pidx(`PM_CFG, cond_prog)][`CFG_AUTOFREE]) begin
                    temp_mask[cond_prog] <= pmem[pidx(`PM_MASK, cond_prog)];
                end
            end else if (cond_reset) begin
                pp[cond_prog]           <= rp[cond_prog];
                prog_running[cond_prog] <= en[cond_prog];
            end else if (jump_take && armed[cond_prog]) begin
                pp[cond_prog]           <= jump_which ? br_targ[cond_prog][7:4]
                                                      : br_targ[cond_prog][3:0];
                armed[cond_prog]        <= 1'b0;
                prog_running[cond_prog] <= en[cond_prog];
            end

            // Waits released by the host or by the other program
            for (i = 0; i < 2; i = i + 1) begin
                if (hold[i] && !output_pending[i]) begin
                    hold[i] <= 1'b0;
                end
            end
            if (sync_done) begin
                sync <= 2'b00;
            end

            // Command step, one command per clock
            if (act) begin
                if (illegal) begin
                    en[svc]           <= 1'b0;
                    prog_running[svc] <= 1'b0;
                end else if (!is_cmd) begin
                    prog_running[svc] <= 1'b0;
                end else begin
                    pp[svc] <= npp;
                    case (op)
                        `OP_HALT: begin
                            en[svc]           <= 1'b0;
                            prog_running[svc] <= 1'b0;
                            rp[svc]           <= `RST_PTR;
                            if (emit) begin
                                outreg[svc]         <= pmem[pidx(`PM_TRIG, svc)];
                                output_pending[svc] <= 1'b1;
                            end
                        end
                        `OP_RESUME: begin
                            pp[svc] <= rp[svc];
                            if (emit) begin
                                outreg[svc]         <= pmem[pidx(`PM_TRIG, svc)];
                                output_pending[svc] <= 1'b1;
                            end
                        end
                        `OP_BRANCH: begin
                            pp[svc]      <= cpp;
                            br_cond[svc] <= par1;
                            br_targ[svc] <= par2;
                            armed[svc]   <= 1'b1;
                        end
                        `OP_MARK_RP: begin
                            rp[svc] <= npp;
                        end
                        `OP_CLEAR_RP: begin
                            rp[svc] <= `RST_PTR;
                        end
                        `OP_WRITE_PARAM_DIRECT: begin
                            if (par1[7:4] == 4'h0) begin
                                pmem[par1[3:0]] <= par2;
                            end
                        end
                        `OP_CFG1: begin
                            pmem[`PM_CFG] <= par1;
                        end
                        `OP_THR1: begin
                            pmem[pidx(`PM_THR1, svc)] <= par1;
                        end
                        `OP_THR2: begin
                            pmem[pidx(`PM_THR2, svc)] <= par1;
                        end
                        `OP_THR3: begin
                            pmem[`PM_THR3] <= par1;
                        end
                        `OP_TIM3: begin
                            pmem[pidx(`PM_TIM3, svc)] <= par1;
                        end
                        `OP_TIM4: begin
                            pmem[pidx(`PM_TIM4, svc)] <= par1;
                        end
                        `OP_PUB: begin
                            outreg[svc]         <= pmem[pidx(`PM_TRIG, svc)];
                            output_pending[svc] <= 1'b1;
                        end
                        `OP_PUB_HOLD: begin
                            outreg[svc]         <= pmem[pidx(`PM_TRIG, svc)];
                            output_pending[svc] <= 1'b1;
                            hold[svc]           <= 1'b1;
                        end
                        `OP_LCNT_DOWN: begin
                            pmem[`PM_LCNT] <= lcnt - 8'h01;
                            if (lcnt == 8'h01) begin
                                counter_hit <= 1'b1;
                            end
                        end
                        `OP_SIGN_FLIP: begin
                            pmem[pidx(`PM_MASK, svc)] <=
                                swap_sign(pmem[pidx(`PM_MASK, svc)]);
                            pmem[pidx(`PM_TRIG, svc)] <=
                                swap_sign(pmem[pidx(`PM_TRIG, svc)]);
                        end
                        `OP_FREE_TEMP: begin
                            temp_mask[svc] <= pmem[pidx(`PM_MASK, svc)];
                        end
                        `OP_RENDEZVOUS: begin
                            sync[svc] <= 1'b1;
                        end
                        `OP_UNSIGNED: begin
                            pmem[pidx(`PM_CFG, svc)][`CFG_SIGNED] <= 1'b0;
                        end
                        `OP_SIGNED: begin
                            pmem[pidx(`PM_CFG, svc)][`CFG_SIGNED] <= 1'b1;
                        end
                        `OP_MAIN_MASK: begin
                            msel[svc] <= 1'b0;
                        end
                        `OP_ALT_MASK: begin
                            msel[svc] <= 1'b1;
                        end
                        `OP_RAW: begin
                            pmem[pidx(`PM_CFG, 1'b1)][`CFG_DELTA] <= 1'b0;
                        end
                        `OP_DELTA: begin
                            pmem[pidx(`PM_CFG, 1'b1)][`CFG_DELTA] <= 1'b1;
                        end
                        `OP_PLAIN_DIFF: begin
                            pmem[pidx(`PM_CFG, 1'b1)][`CFG_DSHIFT] <= 1'b0;
                        end
                        `OP_SHIFT_DIFF: begin
                            pmem[pidx(`PM_CFG, 1'b1)][`CFG_DSHIFT] <= 1'b1;
                        end
                        `OP_KEEP_TEMP: begin
                            pmem[pidx(`PM_CFG, svc)][`CFG_AUTOFREE] <= 1'b0;
                        end
                        `OP_AUTO_FREE: begin
                            pmem[pidx(`PM_CFG, svc)][`CFG_AUTOFREE] <= 1'b1;
                        end
                        default: begin
                            pp[svc] <= npp;
                        end
                    endcase
                end
            end
        end
    end

endmodule
